// file: spi_fault_pkg.sv
// Shared types and constants for the serial port fault and power block
package spi_fault_pkg;

  localparam int          DATA_W       = 8;
  localparam int          FIFO_DEPTH   = 8;
  localparam logic [3:0]  BIT_COUNT    = 4'h8;
  localparam logic [7:0]  DATA_RESET   = 8'h00;
  localparam logic [7:0]  DIV_RESET    = 8'h00;
  // Divider terminal count; the serial clock half period is this plus one system clock
  localparam logic [7:0]  HALF_PERIOD  = 8'h04;
  localparam logic [1:0]  SYNC_RESET   = 2'h0;

  // Control bits as seen by the block
  typedef struct packed {
    logic serial_port_enable;
    logic master_select_req;
    logic mode_fault_enable;
    logic select_output_enable;
    logic stop_in_wait_select;
    logic bidir_mode;
    logic bidir_output_enable_req;
    logic echo_mode;
  } ctrl_t;

  // Flags seen by software
  typedef struct packed {
    logic mode_fault_flag;
    logic receive_complete_flag;
    logic transmit_empty_flag;
  } status_t;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_LEAD  = 2'b01,
    ST_SHIFT = 2'b11,
    ST_DONE  = 2'b10
  } xfer_state_t;

  // Pin outputs with active-low output enables
  typedef struct packed {
    logic sck_o;
    logic sck_oe_n;
    logic mosi_o;
    logic mosi_oe_n;
    logic miso_o;
    logic miso_oe_n;
    logic ss_o;
    logic ss_oe_n;
  } pins_t;

endpackage

// file: spi_fault_sva.sv
// Concurrent checks on the serial port fault and power block
`timescale 1ns/1ns
module spi_fault_sva (
  // Clock and reset
  input wire logic                   SYS_CLK,
  input wire logic                   NRST,
  // Control
  input wire spi_fault_pkg::ctrl_t   CTRL,
  input wire logic                   CTRL1_WR,
  input wire logic                   STATUS_RD,
  input wire logic                   DATA_RD,
  input wire logic                   WAIT_MODE,
  input wire logic                   STOP_MODE,
  input wire logic                   SS_N_I,
  // Outputs
  input wire spi_fault_pkg::status_t STATUS,
  input wire logic                   MASTER_ACTIVE,
  input wire logic                   BIDIR_OE,
  input wire logic                   IRQ,
  input wire spi_fault_pkg::pins_t   PINS
);
  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (!NRST);

  wire master_select = CTRL.serial_port_enable && CTRL.master_select_req;
  wire mf   = STATUS.mode_fault_flag;
  wire rxf  = STATUS.receive_complete_flag;

  property p_irq;
    IRQ == (CTRL.serial_port_enable && (|STATUS));
  endproperty
  a_irq: assert property (p_irq)
    else $error("interrupt request does not match flags");

  // Four samples of a low select cover the two sync flops
  property p_fault_set;
    (master_select && CTRL.mode_fault_enable && !CTRL.select_output_enable
      && !SS_N_I && !CTRL1_WR)[*4] |-> mf;
  endproperty
  a_fault_set: assert property (p_fault_set)
    else $error("mode fault not raised");

  property p_no_fault_off;
    (master_select && !CTRL.mode_fault_enable)[*4] |-> !$rose(mf);
  endproperty
  a_no_fault_off: assert property (p_no_fault_off)
    else $error("mode fault raised with detection off");

  property p_no_fault_ssout;
    (master_select && CTRL.select_output_enable)[*4] |-> !$rose(mf);
  endproperty
  a_no_fault_ssout: assert property (p_no_fault_ssout)
    else $error("mode fault raised with select output on");

  property p_no_fault_slave;
    (!CTRL.master_select_req)[*4] |-> !$rose(mf);
  endproperty
  a_no_fault_slave: assert property (p_no_fault_slave)
    else $error("mode fault raised in slave mode");

  property p_fault_release;
    mf |-> !MASTER_ACTIVE && !BIDIR_OE && PINS.sck_oe_n
      && PINS.mosi_oe_n && PINS.miso_oe_n;
  endproperty
  a_fault_release: assert property (p_fault_release)
    else $error("pins or master still active under mode fault");

  property p_fault_clear;
    $fell(mf) |-> $past(CTRL1_WR);
  endproperty
  a_fault_clear: assert property (p_fault_clear)
    else $error("mode fault cleared without control write");

  property p_rxf_hold;
    rxf && !STATUS_RD && !DATA_RD |=> rxf;
  endproperty
  a_rxf_hold: assert property (p_rxf_hold)
    else $error("receive flag dropped without service");

  property p_rxf_defer;
    (!CTRL.master_select_req && (STOP_MODE
      || (WAIT_MODE && CTRL.stop_in_wait_select)))[*3] |-> !$rose(rxf);
  endproperty
  a_rxf_defer: assert property (p_rxf_defer)
    else $error("receive flag set during low power");

  property p_freeze;
    (MASTER_ACTIVE && (STOP_MODE || (WAIT_MODE && CTRL.stop_in_wait_select)))
      [*2] |-> $stable(PINS.sck_o);
  endproperty
  a_freeze: assert property (p_freeze)
    else $error("serial clock moved while frozen");
endmodule

// file: spi_fault_top.sv
// Serial port with mode fault, low-power handling, FIFO and interrupt
`timescale 1ns/1ns

// Transmit FIFO held in flip-flops
module spi_tx_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             flush,
  // Fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wr;
    logic [AW-1:0]               rd;
    logic [AW:0]                 cnt;
  } fifo_state_t;

  fifo_state_t s_r;
  fifo_state_t s_nxt;
  logic        push;
  logic        pop;

  assign in_ready  = (s_r.cnt != (AW+1)'(DEPTH));
  assign out_valid = (s_r.cnt != '0);
  assign out_data  = s_r.mem[s_r.rd];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb
  begin
    s_nxt = s_r;
    if (flush)
    begin
      s_nxt.wr  = '0;
      s_nxt.rd  = '0;
      s_nxt.cnt = '0;
    end
    else
    begin
      if (push)
      begin
        s_nxt.mem[s_r.wr] = in_data;
        s_nxt.wr          = s_r.wr + AW'(1);
      end
      if (pop)
        s_nxt.rd = s_r.rd + AW'(1);
      if (push && !pop)
        s_nxt.cnt = s_r.cnt + (AW+1)'(1);
      else if (pop && !push)
        s_nxt.cnt = s_r.cnt - (AW+1)'(1);
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end
endmodule

module spi_fault_top (
  // Clock and reset
  input  wire logic                   SYS_CLK,
  input  wire logic                   NRST,
  // Control
  input  wire spi_fault_pkg::ctrl_t   CTRL,
  input  wire logic                   CTRL1_WR,
  input  wire logic                   STATUS_RD,
  input  wire logic                   DATA_RD,
  input  wire logic                   WAIT_MODE,
  input  wire logic                   STOP_MODE,
  // Transmit data
  input  wire logic                   TX_VALID,
  output logic                        TX_READY,
  input  wire logic [7:0]             TX_DATA,
  // Status and data
  output spi_fault_pkg::status_t      STATUS,
  output logic [7:0]                  RX_DATA,
  output logic                        MASTER_ACTIVE,
  output logic                        BIDIR_OE,
  output logic                        IRQ,
  // Link pins
  input  wire logic                   SCK_I,
  input  wire logic                   MOSI_I,
  input  wire logic                   MISO_I,
  input  wire logic                   SS_N_I,
  output spi_fault_pkg::pins_t        PINS
);
  typedef struct packed {
    logic [7:0]                  hold;
    logic                        rx_bit;
    logic [1:0]                  sck_s;
    logic [1:0]                  mosi_s;
    logic [1:0]                  miso_s;
    logic [1:0]                  ss_s;
    logic                        sck_d;
    spi_fault_pkg::xfer_state_t  st;
    logic [7:0]                  shift;
    logic [7:0]                  data;
    logic [3:0]                  bits;
    logic [7:0]                  div;
    logic                        sck;
    logic                        fault;
    logic                        rxf;
    logic                        txe;
    logic                        fault_seen;
    logic                        slave_busy;
    logic                        rx_pend;
    logic                        lp_touch;
    logic                        lp_d;
    logic                        echo_lat;
  } top_state_t;

  top_state_t s_r;
  top_state_t s_nxt;
  logic [1:0] rst_sync_r;
  logic       rst_n;
  logic       echo_sel;
  logic [7:0] tx_src;
  logic       fifo_valid;
  logic       fifo_pop;
  logic [7:0] fifo_data;
  logic       is_master;
  logic       low_power;
  logic       master_halt;
  logic       sck_rise;
  logic       sck_fall;
  logic       ss_in_low;
  logic       rx_in;

  assign rst_n = rst_sync_r[1];

  spi_tx_fifo #(
    .WIDTH (spi_fault_pkg::DATA_W),
    .DEPTH (spi_fault_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk       (SYS_CLK),
    .rst_n     (rst_n),
    .flush     (1'b0),
    .in_valid  (TX_VALID),
    .in_ready  (TX_READY),
    .in_data   (TX_DATA),
    .out_valid (fifo_valid),
    .out_ready (fifo_pop),
    .out_data  (fifo_data)
  );

  // Fault forces slave until software clears it
  assign is_master   = CTRL.master_select_req && !s_r.fault;
  // Stop ignores stop-in-wait; wait only counts with it set
  assign low_power   = STOP_MODE
                       || (WAIT_MODE && CTRL.stop_in_wait_select);
  assign master_halt = low_power;
  assign ss_in_low   = !s_r.ss_s[1];
  assign sck_rise    = s_r.sck_s[1] && !s_r.sck_d;
  assign sck_fall    = !s_r.sck_s[1] && s_r.sck_d;
  assign rx_in       = is_master
                       ? (CTRL.bidir_mode ? s_r.mosi_s[1] : s_r.miso_s[1])
                       : (CTRL.bidir_mode ? s_r.miso_s[1] : s_r.mosi_s[1]);
  assign fifo_pop    = CTRL.serial_port_enable && is_master && !master_halt
                       && s_r.st == spi_fault_pkg::ST_IDLE && fifo_valid;
  // Mode latched at low-power entry governs the reply until exit
  assign echo_sel    = low_power ? s_r.echo_lat : CTRL.echo_mode;
  assign tx_src      = fifo_valid ? fifo_data : s_r.data;

  always_comb
  begin
    s_nxt          = s_r;
    s_nxt.sck_s    = {s_r.sck_s[0], SCK_I};
    s_nxt.mosi_s   = {s_r.mosi_s[0], MOSI_I};
    s_nxt.miso_s   = {s_r.miso_s[0], MISO_I};
    s_nxt.ss_s     = {s_r.ss_s[0], SS_N_I};
    s_nxt.sck_d    = s_r.sck_s[1];
    s_nxt.lp_d     = low_power;
    s_nxt.txe      = s_r.txe || TX_READY;

    // Fault clear sequence: status read arms, control write clears
    if (STATUS_RD && s_r.fault)
      s_nxt.fault_seen = 1'b1;
    if (CTRL1_WR && s_r.fault_seen)
    begin
      s_nxt.fault      = 1'b0;
      s_nxt.fault_seen = 1'b0;
    end
    // Clears come first so that a same-cycle set wins
    if (STATUS_RD || DATA_RD)
      s_nxt.rxf = 1'b0;
    if (!TX_READY)
      s_nxt.txe = 1'b0;

    if (!CTRL.serial_port_enable)
    begin
      // Core idles; data stays as it is, flags still follow reads, control writes and TX_READY
      s_nxt.st  = spi_fault_pkg::ST_IDLE;
      s_nxt.sck = 1'b0;
    end
    else if (is_master)
    begin
      // Detection off without enable or with automatic select output
      if (CTRL.mode_fault_enable && !CTRL.select_output_enable
          && ss_in_low)
      begin
        s_nxt.fault   = 1'b1;
        s_nxt.st      = spi_fault_pkg::ST_IDLE;
        s_nxt.sck     = 1'b0;
        s_nxt.bits    = '0;
        s_nxt.rx_pend = 1'b0;
      end
      else if (!master_halt)
      begin
        unique case (s_r.st)
          spi_fault_pkg::ST_IDLE:
            if (fifo_pop)
            begin
              s_nxt.shift = fifo_data;
              s_nxt.bits  = '0;
              s_nxt.div   = spi_fault_pkg::DIV_RESET;
              s_nxt.st    = spi_fault_pkg::ST_LEAD;
            end
          spi_fault_pkg::ST_LEAD:
            if (s_r.div == spi_fault_pkg::HALF_PERIOD)
            begin
              s_nxt.div = spi_fault_pkg::DIV_RESET;
              s_nxt.st  = spi_fault_pkg::ST_SHIFT;
            end
            else
              s_nxt.div = s_r.div + 8'h01;
          spi_fault_pkg::ST_SHIFT:
            if (s_r.div == spi_fault_pkg::HALF_PERIOD)
            begin
              s_nxt.div = spi_fault_pkg::DIV_RESET;
              s_nxt.sck = !s_r.sck;
              // Sample on rising, move the output only on falling
              if (!s_r.sck)
                s_nxt.rx_bit = rx_in;
              else
              begin
                s_nxt.shift = {s_r.shift[6:0], s_r.rx_bit};
                if (s_r.bits == spi_fault_pkg::BIT_COUNT - 4'h1)
                  s_nxt.st = spi_fault_pkg::ST_DONE;
                else
                  s_nxt.bits = s_r.bits + 4'h1;
              end
            end
            else
              s_nxt.div = s_r.div + 8'h01;
          spi_fault_pkg::ST_DONE:
          begin
            s_nxt.data = s_r.shift;
            s_nxt.rxf  = 1'b1;
            s_nxt.st   = spi_fault_pkg::ST_IDLE;
          end
        endcase
      end
    end
    else
    begin
      // Slave: select is input only and never faults
      s_nxt.slave_busy = ss_in_low;
      if (low_power && !s_r.lp_d)
      begin
        s_nxt.rx_pend  = 1'b0;
        s_nxt.echo_lat = CTRL.echo_mode;
      end
      if (low_power && ss_in_low)
        s_nxt.lp_touch = 1'b1;
      if (!ss_in_low)
      begin
        s_nxt.bits = '0;
        if (!echo_sel)
          s_nxt.shift = tx_src;
      end
      else if (sck_rise)
        s_nxt.rx_bit = rx_in;
      else if (sck_fall)
      begin
        // Shifting runs on the master's clock; output moves on falling
        s_nxt.shift = {s_r.shift[6:0], s_r.rx_bit};
        if (s_r.bits == spi_fault_pkg::BIT_COUNT - 4'h1)
        begin
          // Byte set aside so the shift register can reload the reply
          s_nxt.hold    = {s_r.shift[6:0], s_r.rx_bit};
          s_nxt.bits    = '0;
          s_nxt.rx_pend = 1'b1;
          if (!echo_sel)
            s_nxt.shift = tx_src;
        end
        else
          s_nxt.bits = s_r.bits + 4'h1;
      end
      if (s_r.rx_pend && !low_power)
      begin
        // After a low-power exit, copy only when the window touched a transfer
        if (!s_r.lp_d || s_r.lp_touch)
        begin
          s_nxt.data = s_r.hold;
          s_nxt.rxf  = 1'b1;
        end
        s_nxt.rx_pend  = 1'b0;
        s_nxt.lp_touch = 1'b0;
      end
      s_nxt.st  = spi_fault_pkg::ST_IDLE;
      s_nxt.sck = 1'b0;
    end
  end

  always_ff @(posedge SYS_CLK or negedge NRST)
  begin
    if (!NRST)
      rst_sync_r <= spi_fault_pkg::SYNC_RESET;
    else
      rst_sync_r <= {rst_sync_r[0], 1'b1};
  end

  always_ff @(posedge SYS_CLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_r.sck_s      <= '0;
      s_r.mosi_s     <= '0;
      s_r.miso_s     <= '0;
      s_r.ss_s       <= 2'h3;
      s_r.sck_d      <= 1'b0;
      s_r.st         <= spi_fault_pkg::ST_IDLE;
      s_r.shift      <= spi_fault_pkg::DATA_RESET;
      s_r.data       <= spi_fault_pkg::DATA_RESET;
      s_r.bits       <= '0;
      s_r.div        <= spi_fault_pkg::DIV_RESET;
      s_r.sck        <= 1'b0;
      s_r.fault      <= 1'b0;
      s_r.rxf        <= 1'b0;
      s_r.txe        <= 1'b0;
      s_r.fault_seen <= 1'b0;
      s_r.slave_busy <= 1'b0;
      s_r.rx_pend    <= 1'b0;
      s_r.lp_touch   <= 1'b0;
      s_r.lp_d       <= 1'b0;
      s_r.echo_lat   <= 1'b0;
      s_r.hold       <= spi_fault_pkg::DATA_RESET;
      s_r.rx_bit     <= 1'b0;
    end
    else
      s_r <= s_nxt;
  end

  always_comb
  begin
    PINS           = '1;
    PINS.sck_o     = s_r.sck;
    PINS.mosi_o    = s_r.shift[7];
    PINS.miso_o    = s_r.shift[7];
    PINS.ss_o      = (s_r.st == spi_fault_pkg::ST_IDLE);
    // Fault leaves every pin released as an input
    if (CTRL.serial_port_enable && is_master)
    begin
      PINS.sck_oe_n  = 1'b0;
      PINS.mosi_oe_n = !(!CTRL.bidir_mode || BIDIR_OE);
      PINS.ss_oe_n   = !(CTRL.mode_fault_enable && CTRL.select_output_enable);
    end
    else if (CTRL.serial_port_enable && !s_r.fault && s_r.slave_busy)
      PINS.miso_oe_n = !(!CTRL.bidir_mode || CTRL.bidir_output_enable_req);
  end

  // Fault drops the shared pin's drive until cleared
  assign BIDIR_OE      = CTRL.bidir_output_enable_req && !s_r.fault;
  assign MASTER_ACTIVE = is_master;
  assign RX_DATA       = s_r.data;
  assign STATUS        = '{mode_fault_flag:       s_r.fault,
                           receive_complete_flag: s_r.rxf,
                           transmit_empty_flag:   s_r.txe};
  assign IRQ = CTRL.serial_port_enable
               && (s_r.fault || s_r.rxf || s_r.txe);
endmodule

// file: spi_link_peer.sv
// Far-side serial device: echoing slave, or master with its own clock
`timescale 1ns/1ns
module spi_link_peer (
  // Wires as resolved
  input  wire logic sck,
  input  wire logic mosi,
  input  wire logic miso,
  // Driven by this device
  output logic      sck_drv,
  output logic      mosi_drv,
  output logic      miso_drv,
  output logic      ss_n_drv
);
  logic [7:0] sr = 8'hA5;
  logic       bit_in = 1'b0;

  initial
  begin
    sck_drv = 1'b0;
    mosi_drv = 1'b0;
    ss_n_drv = 1'b1;
  end

  // Slave side returns the previous byte, so replies are predictable
  always @(posedge sck) bit_in <= mosi;
  always @(negedge sck) sr <= {sr[6:0], bit_in};
  assign miso_drv = sr[7];

  // Master side, 80 ns period; clock stands low between frames
  task automatic xfer(input logic [7:0] d, output logic [7:0] q);
    #40 ss_n_drv = 1'b0;
    #40;
    for (int i = 7; i >= 0; i--)
    begin
      mosi_drv = d[i];
      #40 sck_drv = 1'b1;
      #39 q[i] = miso;
      #1 sck_drv = 1'b0;
    end
    mosi_drv = ~mosi_drv;
    #40 ss_n_drv = 1'b1;
  endtask
endmodule

// file: tb_top.sv
// Self-checking bench for the serial port fault and power block
`timescale 1ns/1ns
module tb_top;
  logic                   clk = 1'b0;
  logic                   nrst = 1'b0;
  spi_fault_pkg::ctrl_t   ctrl = '0;
  logic                   wr1 = 1'b0;
  logic                   srd = 1'b0;
  logic                   drd = 1'b0;
  logic                   wt = 1'b0;
  logic                   stp = 1'b0;
  logic                   tv = 1'b0;
  logic [7:0]             td = 8'h00;
  logic                   tr, irq, mact, boe;
  logic [7:0]             rx;
  spi_fault_pkg::status_t st;
  spi_fault_pkg::pins_t   pins;
  logic                   sck_w, mosi_w, miso_w, sck_d, mosi_d, miso_d, ss_d;
  logic [7:0]             expq[$];
  logic [31:0]            seed = 32'h00000058;
  int                     failures = 0;
  int                     n_compared = 0;

  always #5 clk = ~clk;
  assign sck_w  = pins.sck_oe_n ? sck_d : pins.sck_o;
  assign mosi_w = pins.mosi_oe_n ? mosi_d : pins.mosi_o;
  assign miso_w = pins.miso_oe_n ? miso_d : pins.miso_o;

  spi_fault_top dut (.SYS_CLK(clk), .NRST(nrst), .CTRL(ctrl), .CTRL1_WR(wr1),
    .STATUS_RD(srd), .DATA_RD(drd), .WAIT_MODE(wt), .STOP_MODE(stp),
    .TX_VALID(tv), .TX_READY(tr), .TX_DATA(td), .STATUS(st), .RX_DATA(rx),
    .MASTER_ACTIVE(mact), .BIDIR_OE(boe), .IRQ(irq), .SCK_I(sck_w),
    .MOSI_I(mosi_w), .MISO_I(miso_w),
    .SS_N_I(ss_d & (pins.ss_oe_n | pins.ss_o)), .PINS(pins));

  spi_link_peer peer (.sck(sck_w), .mosi(mosi_w), .miso(miso_w),
    .sck_drv(sck_d), .mosi_drv(mosi_d), .miso_drv(miso_d), .ss_n_drv(ss_d));

  function automatic logic [7:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[7:0];
  endfunction

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      failures++;
      $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask

  // Valid stays up between pushes; caller drops it after the last
  task automatic push(input logic [7:0] d);
    tv = 1'b1;
    td = d;
    for (int k = 0; k < 3000 && tr !== 1'b1; k++)
      tick(1);
    tick(1);
  endtask

  task automatic drain();
    for (int k = 0; k < 3000 && expq.size() > 0; k++)
      tick(1);
    tick(4);
    chk(8'(expq.size()), 8'h00);
  endtask

  task automatic report_and_stop();
    $display("compared %0d, failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // Services each received byte like software and checks it
  always @(negedge clk)
    if (st.receive_complete_flag === 1'b1 && !drd)
    begin
      drd = 1'b1;
      if (expq.size() > 0)
        chk(rx, expq.pop_front());
      else
        chk(rx, 8'hXX);
    end
    else
      drd = 1'b0;

  initial
  begin
    #400000;
    failures++;
    report_and_stop();
  end

  initial
  begin
    logic [7:0] a;
    logic [7:0] last;
    logic [7:0] q;
    tick(8);
    nrst = 1'b1;
    tick(3);
    chk(rx, 8'h00);
    chk(irq, 1'b0);
    $display("reset test done");
    last = 8'hA5;
    for (int i = 0; i < 8; i++)
    begin
      a = rnd();
      push(a);
      expq.push_back(last);
      last = a;
    end
    tv = 1'b0;
    tick(2);
    chk(tr, 1'b0);
    chk(st.transmit_empty_flag, 1'b0);
    ctrl = '{serial_port_enable: 1'b1, master_select_req: 1'b1,
      mode_fault_enable: 1'b1, default: 1'b0};
    drain();
    chk(st.transmit_empty_flag, 1'b1);
    chk(irq, 1'b1);
    $display("fill and drain test done");
    for (int i = 0; i < 4; i++)
    begin
      ctrl.stop_in_wait_select = i[0];
      a = rnd();
      push(a);
      tv = 1'b0;
      expq.push_back(last);
      last = a;
      tick(30);
      wt = (i < 2);
      stp = (i >= 2);
      tick(40);
      wt = 1'b0;
      stp = 1'b0;
      drain();
    end
    $display("low power master test done");
    ctrl = '{serial_port_enable: 1'b1, echo_mode: 1'b1,
      stop_in_wait_select: 1'b1, default: 1'b0};
    tick(2);
    wt = 1'b1;
    tick(5);
    wt = 1'b0;
    a = rnd();
    expq.push_back(a);
    #3 peer.xfer(a, q);
    last = rnd();
    expq.push_back(last);
    peer.xfer(last, q);
    chk(q, a);
    a = rnd();
    expq.push_back(a);
    fork
      peer.xfer(a, q);
      begin
        tick(20);
        wt = 1'b1;
      end
    join
    tick(10);
    chk(st.receive_complete_flag, 1'b0);
    wt = 1'b0;
    chk(q, last);
    drain();
    $display("slave test done");
    for (int i = 0; i < 4; i++)
    begin
      ctrl = '{serial_port_enable: 1'b1, master_select_req: (i != 3),
        mode_fault_enable: (i != 1), select_output_enable: (i == 2),
        bidir_mode: 1'b1, bidir_output_enable_req: 1'b1, default: 1'b0};
      wr1 = 1'b1;
      tick(1);
      wr1 = 1'b0;
      if (i == 0)
      begin
        push(rnd());
        tv = 1'b0;
        tick(20);
      end
      peer.ss_n_drv = 1'b0;
      tick(6);
      chk(st.mode_fault_flag, (i == 0));
      chk(pins.ss_oe_n, (i != 2));
      peer.ss_n_drv = 1'b1;
      if (i == 0)
      begin
        chk({mact, boe, irq}, 3'h1);
        chk({pins.sck_oe_n, pins.mosi_oe_n, pins.miso_oe_n}, 3'h7);
        wr1 = 1'b1;
        tick(1);
        wr1 = 1'b0;
        tick(2);
        chk(st.mode_fault_flag, 1'b1);
        srd = 1'b1;
        tick(1);
        srd = 1'b0;
        wr1 = 1'b1;
        tick(1);
        wr1 = 1'b0;
        tick(2);
        chk({st.mode_fault_flag, mact}, 2'h1);
      end
      tick(10);
    end
    $display("mode fault test done");
    report_and_stop();
  end
endmodule

bind spi_fault_top spi_fault_sva chk_i (.SYS_CLK(SYS_CLK), .NRST(NRST),
  .CTRL(CTRL), .CTRL1_WR(CTRL1_WR), .STATUS_RD(STATUS_RD),
  .DATA_RD(DATA_RD), .WAIT_MODE(WAIT_MODE), .STOP_MODE(STOP_MODE),
  .SS_N_I(SS_N_I), .STATUS(STATUS), .MASTER_ACTIVE(MASTER_ACTIVE),
  .BIDIR_OE(BIDIR_OE), .IRQ(IRQ), .PINS(PINS));
